// ---- design/hwirq_pkg.sv ----
// package for the hardware interrupt register triplet
package hwirq_pkg;
  // register offsets on the register port
  localparam logic [15:0] HWIRQ_PENDING_OFS = 16'h0006;
  localparam logic [15:0] HWIRQ_ENABLE_OFS = 16'h000f;
  localparam logic [15:0] HWIRQ_OUT_EN_OFS = 16'h0013;
  // bit positions: 15..13 shared by all three registers, summary bits 2 and 0 in pending only
  localparam int HWIRQ_HOST_LINK_BIT = 15;
  localparam int HWIRQ_EEPROM_BIT = 14;
  localparam int HWIRQ_RAM_BIT = 13;
  localparam int HWIRQ_RT_SUM_BIT = 2;
  localparam int HWIRQ_BC_SUM_BIT = 0;
  // reset values and writable masks
  localparam logic [15:0] HWIRQ_ENABLE_RST = 16'h6000;
  localparam logic [15:0] HWIRQ_OUT_EN_RST = 16'h6000;
  localparam logic [15:0] HWIRQ_PENDING_RST = 16'h0000;
  localparam logic [15:0] HWIRQ_ENABLE_WMASK = 16'hffe0;
  localparam logic [15:0] HWIRQ_OUT_EN_WMASK = 16'hfff8;
  localparam logic [15:0] HWIRQ_PEND_CLR_MASK = 16'hfff8;
  localparam logic [15:0] HWIRQ_LOG_ADDR_WORD = 16'h0000;
  // transmitter watchdog timing
  localparam int HWIRQ_CLK_PERIOD_PS = 4000;
  localparam int HWIRQ_WDOG_TIME_NS = 663000;
  localparam int HWIRQ_WDOG_CYCLES = (HWIRQ_WDOG_TIME_NS * 1000) / HWIRQ_CLK_PERIOD_PS;
  localparam int HWIRQ_WDOG_CNT_W = 18;
  localparam int HWIRQ_TX_COUNT = 2;

  typedef struct packed {
    logic host_frame_err;
    logic eeprom_checksum_err;
    logic ram_init_mismatch;
    logic ram_parity_fail;
  } hwirq_event_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hwirq_req_type;
endpackage

// ---- design/hwirq_tx_watchdog.sv ----
// continuous transmission watchdog for one bus transmitter
`timescale 1ns/100ps
module hwirq_tx_watchdog
  import hwirq_pkg::*;
#(
  parameter int LIMIT = HWIRQ_WDOG_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tx_active,
  output logic tx_inhibit,
  output logic timeout
);
  logic [HWIRQ_WDOG_CNT_W-1:0] cnt_q;
  logic [HWIRQ_WDOG_CNT_W-1:0] cnt_d;
  logic inhibit_q;
  logic inhibit_d;
  logic hit;
  localparam logic [HWIRQ_WDOG_CNT_W-1:0] LAST = HWIRQ_WDOG_CNT_W'(LIMIT - 1);

  // counts cycles of transmission, trips once at the limit
  assign hit = tx_active && !inhibit_q && (cnt_q == LAST);
  assign cnt_d = !tx_active ? '0 : (inhibit_q ? cnt_q : cnt_q + 1'b1);
  assign inhibit_d = tx_active && (inhibit_q || hit);
  assign tx_inhibit = inhibit_q;
  assign timeout = hit;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      inhibit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d; // see R12
      inhibit_q <= inhibit_d; // see R12
    end
  end

  trip_stops_tx_a: assert property (@(posedge mclk) disable iff (!reset_n) // see R12
    hit |=> tx_inhibit)
    else $error("watchdog did not stop transmitter");
  inhibit_holds_a: assert property (@(posedge mclk) disable iff (!reset_n) // see R12
    (tx_inhibit && tx_active) |=> tx_inhibit)
    else $error("watchdog released a running transmitter");
  no_early_trip_a: assert property (@(posedge mclk) disable iff (!reset_n) // see R12
    (tx_active && cnt_q < LAST && !inhibit_q) |=> !tx_inhibit)
    else $error("watchdog tripped early");
endmodule

// ---- design/hwirq_triplet.sv ----
// hardware interrupt enable, pending and output enable registers
//
// Behaviour
// R01 - bits 15..3 share one layout in all three registers
// R02 - enable register bits 4..0 are read-only, host writes ignored
// R03 - output enable bits 2..0 are read-only, host cannot set them
// R04 - pending bits 2 and 0 summarise terminal and controller pending registers
// R05 - bad host serial clock count sets bit 15; resets to zero
// R06 - eeprom and ram-init events work only if auto-init pin high at reset release
// R07 - eeprom checksum failure sets pending 14 and master status bit 1
// R08 - ram parity failure sets bit 13; data is not corrected
// R09 - ram parity failure clears the ram-init-fail master status flag
// R10 - host reads master status to tell init failure from parity failure
// R11 - ram init mismatch sets pending 13 and master status bit 0
// R12 - each transmitter has a watchdog stopping transmission past 663 us
// R13 - enabled watchdog timeout sets pending bit and writes a log entry
// R14 - watchdog timeout drives the request pin when output enable 13 set
// R15 - one two-word log entry per event set, one info bit per event
// R16 - simultaneous output-enabled events OR into one request assertion
// R17 - pending bit 2 high while any terminal pending bit is set
// R18 - pending latches only enabled events; request only for output-enabled pending
`timescale 1ns/100ps
module hwirq_triplet
  import hwirq_pkg::*;
#(
  parameter int WDOG_CYCLES = HWIRQ_WDOG_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic AUTO_INIT_SELECT_PIN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic HOST_LINK_FRAME_ERROR,
  input wire logic EEPROM_CHECKSUM_ERROR,
  input wire logic RAM_INIT_MISMATCH,
  input wire logic RAM_PARITY_FAIL,
  input wire logic TERMINAL_PENDING_ANY,
  input wire logic CONTROLLER_PENDING_ANY,
  input wire logic [HWIRQ_TX_COUNT-1:0] TX_ACTIVE,
  output logic [HWIRQ_TX_COUNT-1:0] TX_INHIBIT,
  input wire logic MSTAT_CLEAR,
  output logic MSTAT_EEPROM_CHECKSUM_FAIL,
  output logic MSTAT_RAM_INIT_FAIL,
  output logic IRQ,
  output logic LOG_WR,
  output logic [15:0] LOG_INFO_WORD,
  output logic [15:0] LOG_ADDR_WORD
);
  hwirq_event_type evt;
  hwirq_req_type req;
  logic [15:0] enable_q, enable_d;
  logic [15:0] out_en_q, out_en_d;
  logic [15:0] pend_q, pend_d;
  logic [15:0] raw_set, new_set, clr_vec;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic [15:0] log_info_q;
  logic log_wr_q;
  logic irq_q;
  logic auto_q;
  logic auto_taken_q;
  logic ee_fail_q, ee_fail_d;
  logic ri_fail_q, ri_fail_d;
  logic [HWIRQ_TX_COUNT-1:0] wdog_trip;
  logic wdog_any;
  logic sel_pend, sel_en, sel_oe;
  logic ee_evt, ri_evt;

  ////////////////////////////////////////////////////////////////////////////
  // per transmitter watchdogs
  genvar g;
  generate
    for (g = 0; g < HWIRQ_TX_COUNT; g = g + 1) begin : g_wdog
      hwirq_tx_watchdog #(.LIMIT(WDOG_CYCLES)) u_wdog (
        .mclk(MCLK),
        .reset_n(RESET_N),
        .tx_active(TX_ACTIVE[g]),
        .tx_inhibit(TX_INHIBIT[g]),
        .timeout(wdog_trip[g])
      ); // see R12
    end
  endgenerate
  assign wdog_any = |wdog_trip;

  ////////////////////////////////////////////////////////////////////////////
  // event collection
  assign evt = '{host_frame_err: HOST_LINK_FRAME_ERROR,
                 eeprom_checksum_err: EEPROM_CHECKSUM_ERROR,
                 ram_init_mismatch: RAM_INIT_MISMATCH,
                 ram_parity_fail: RAM_PARITY_FAIL};
  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
  assign ee_evt = evt.eeprom_checksum_err && auto_q; // see R06
  assign ri_evt = evt.ram_init_mismatch && auto_q; // see R06

  // raw events on the shared bit layout, gated by enable
  assign raw_set = ({evt.host_frame_err, 15'h0000} // see R05
                  | {1'b0, ee_evt, 14'h0000} // see R07
                  | {2'b00, ri_evt || evt.ram_parity_fail || wdog_any, 13'h0000}) // see R08
                  & enable_q; // see R18
  assign new_set = raw_set & ~pend_q; // see R15

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign sel_pend = req.addr == HWIRQ_PENDING_OFS;
  assign sel_en = req.addr == HWIRQ_ENABLE_OFS;
  assign sel_oe = req.addr == HWIRQ_OUT_EN_OFS;
  assign clr_vec = (req.wr && sel_pend) ? (req.wdata & HWIRQ_PEND_CLR_MASK) : 16'h0000;
  assign enable_d = (req.wr && sel_en) ? (req.wdata & HWIRQ_ENABLE_WMASK) : enable_q; // see R02
  assign out_en_d = (req.wr && sel_oe) ? (req.wdata & HWIRQ_OUT_EN_WMASK) : out_en_q; // see R03
  // set wins over a host clear in the same cycle; summaries track live
  assign pend_d = (((pend_q & ~clr_vec) | raw_set) & HWIRQ_PEND_CLR_MASK) // see R01
                | {13'h0000, TERMINAL_PENDING_ANY, 1'b0, CONTROLLER_PENDING_ANY}; // see R04
  assign rdata_d = !req.rd ? rdata_q :
                   sel_pend ? pend_q : sel_en ? enable_q : sel_oe ? out_en_q : 16'h0000;

  // master status flags
  assign ee_fail_d = ee_evt || (ee_fail_q && !MSTAT_CLEAR); // see R07
  assign ri_fail_d = !evt.ram_parity_fail && (ri_evt || (ri_fail_q && !MSTAT_CLEAR)); // see R09

  ////////////////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      enable_q <= HWIRQ_ENABLE_RST;
      out_en_q <= HWIRQ_OUT_EN_RST;
      pend_q <= HWIRQ_PENDING_RST;
      rdata_q <= 16'h0000;
      ee_fail_q <= 1'b0;
      ri_fail_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      out_en_q <= out_en_d;
      pend_q <= pend_d; // see R17
      rdata_q <= rdata_d;
      ee_fail_q <= ee_fail_d;
      ri_fail_q <= ri_fail_d; // see R11
    end
  end

  // auto-init strap caught on the first edge after reset release
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      auto_q <= 1'b0;
      auto_taken_q <= 1'b0;
    end else if (!auto_taken_q) begin
      auto_q <= AUTO_INIT_SELECT_PIN; // see R06
      auto_taken_q <= 1'b1;
    end
  end

  // log entry and request line
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      log_wr_q <= 1'b0;
      log_info_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      log_wr_q <= |new_set; // see R13
      log_info_q <= new_set; // see R15
      irq_q <= |(pend_q & out_en_q); // see R16
    end
  end

  assign REG_RDATA = rdata_q;
  assign LOG_WR = log_wr_q;
  assign LOG_INFO_WORD = log_info_q;
  assign LOG_ADDR_WORD = HWIRQ_LOG_ADDR_WORD;
  assign IRQ = irq_q; // see R14
  assign MSTAT_EEPROM_CHECKSUM_FAIL = ee_fail_q;
  assign MSTAT_RAM_INIT_FAIL = ri_fail_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  irq_follows_pend_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R18
    (|(pend_q & out_en_q)) |=> IRQ)
    else $error("request not raised for output-enabled pending bit");
  irq_quiet_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R16
    !(|(pend_q & out_en_q)) |=> !IRQ)
    else $error("request raised with nothing pending");
  en_low_ro_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R02
    (REG_WR && sel_en) |=> (enable_q[4:0] == 5'h00 && enable_q[15:5] == $past(REG_WDATA[15:5])))
    else $error("enable register write handled wrongly");
  oe_low_ro_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R03
    (REG_WR && sel_oe) |=> out_en_q[2:0] == 3'h0)
    else $error("output enable low bits were set");
  rt_summary_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R17
    TERMINAL_PENDING_ANY |=> pend_q[HWIRQ_RT_SUM_BIT])
    else $error("terminal summary bit missing");
  disabled_event_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R18
    (HOST_LINK_FRAME_ERROR && !enable_q[15] && !pend_q[15]) |=> !pend_q[15])
    else $error("disabled event latched");
  set_wins_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R05
    (HOST_LINK_FRAME_ERROR && enable_q[15]) |=> pend_q[15])
    else $error("enabled host link error lost");
  parity_clears_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R09
    RAM_PARITY_FAIL |=> (!MSTAT_RAM_INIT_FAIL && (pend_q[13] || !$past(enable_q[13]))))
    else $error("parity failure handled wrongly");
  strap_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R06
    (auto_taken_q && !auto_q && EEPROM_CHECKSUM_ERROR) |=> !MSTAT_EEPROM_CHECKSUM_FAIL[*1])
    else $error("eeprom event acted without auto-init strap");
  log_entry_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R13
    (|new_set) |=> (LOG_WR && LOG_INFO_WORD == $past(new_set)))
    else $error("log entry missing for new pending bit");
  log_quiet_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R15
    !(|new_set) |=> !LOG_WR)
    else $error("log entry without new pending bit");
  ctrl_summary_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R04
    CONTROLLER_PENDING_ANY |=> pend_q[HWIRQ_BC_SUM_BIT])
    else $error("controller summary bit missing");
  ee_status_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R07
    (EEPROM_CHECKSUM_ERROR && auto_q) |=> MSTAT_EEPROM_CHECKSUM_FAIL)
    else $error("eeprom status flag not set");
  init_status_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R11
    (RAM_INIT_MISMATCH && auto_q && !RAM_PARITY_FAIL) |=> MSTAT_RAM_INIT_FAIL)
    else $error("ram init status flag not set");
  ram_strap_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R06
    (auto_taken_q && !auto_q && RAM_INIT_MISMATCH) |=> !MSTAT_RAM_INIT_FAIL)
    else $error("ram init event acted without auto-init strap");
  wdog_pend_a: assert property (@(posedge MCLK) disable iff (!RESET_N) // see R13
    (wdog_any && enable_q[HWIRQ_RAM_BIT]) |=> pend_q[HWIRQ_RAM_BIT])
    else $error("watchdog timeout not latched");
endmodule

// ---- verification/hwirq_host_model.sv ----
// host processor model driving the register port
`timescale 1ns/100ps
module hwirq_host_model
  import hwirq_pkg::*;
(
  input wire logic mclk,
  output hwirq_req_type req
);
  initial req = '0;
  // released address and data show the inverse of the last value
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
  endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the interrupt register triplet
`timescale 1ns/100ps
module tb_top
  import hwirq_pkg::*;
();
  localparam int WD = 8;
  logic mclk, reset_n, strap, term_any, ctrl_any, mstat_clear, irq, log_wr, mst_ee, mst_ri;
  logic rd_q = 1'b0;
  hwirq_event_type evt;
  hwirq_req_type req;
  logic [1:0] tx_act, tx_inh;
  logic [15:0] rdata, log_info, log_addr, v;
  logic [15:0] rd_exp[$];
  logic [15:0] log_exp[$];
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  hwirq_host_model u_hwirq_host_model (.mclk(mclk), .req(req));
  hwirq_triplet #(.WDOG_CYCLES(WD)) u_hwirq_triplet (
    .MCLK(mclk), .RESET_N(reset_n), .AUTO_INIT_SELECT_PIN(strap),
    .REG_WR(req.wr), .REG_RD(req.rd), .REG_ADDR(req.addr), .REG_WDATA(req.wdata),
    .REG_RDATA(rdata), .HOST_LINK_FRAME_ERROR(evt.host_frame_err),
    .EEPROM_CHECKSUM_ERROR(evt.eeprom_checksum_err), .RAM_INIT_MISMATCH(evt.ram_init_mismatch),
    .RAM_PARITY_FAIL(evt.ram_parity_fail), .TERMINAL_PENDING_ANY(term_any),
    .CONTROLLER_PENDING_ANY(ctrl_any), .TX_ACTIVE(tx_act), .TX_INHIBIT(tx_inh),
    .MSTAT_CLEAR(mstat_clear), .MSTAT_EEPROM_CHECKSUM_FAIL(mst_ee),
    .MSTAT_RAM_INIT_FAIL(mst_ri), .IRQ(irq), .LOG_WR(log_wr), .LOG_INFO_WORD(log_info),
    .LOG_ADDR_WORD(log_addr));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // monitor: oldest note against each result
  always @(posedge mclk) begin
    rd_q <= req.rd;
    cyc <= cyc + 1;
    if (rd_q) chk("rdata", rdata, rd_exp.pop_front());
    if (log_wr === 1'b1) begin
      chk("log_info", log_info, log_exp.size() ? log_exp.pop_front() : 16'hdead);
      chk("log_addr", log_addr, HWIRQ_LOG_ADDR_WORD);
    end
    if (cyc == 6000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rd_exp.push_back(e);
    u_hwirq_host_model.rd(a);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_hwirq_host_model.wr(a, d);
  endtask
  task automatic do_reset(input logic s);
    reset_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  task automatic fire(input logic [3:0] e, input logic [15:0] lg, input logic ex_irq);
    @(posedge mclk);
    evt <= hwirq_event_type'(e);
    @(posedge mclk);
    evt <= '0;
    if (lg != 16'h0000) log_exp.push_back(lg);
    repeat (3) @(posedge mclk);
    chk("irq", {15'h0000, irq}, {15'h0000, ex_irq});
  endtask
  task automatic clr_chk();
    wr(HWIRQ_PENDING_OFS, 16'hffff);
    repeat (2) @(posedge mclk);
    chk("irq_clr", {15'h0000, irq}, 16'h0000);
  endtask

  initial begin
    reset_n = 1'b0;
    strap = 1'b1;
    evt = '0;
    term_any = 1'b0;
    ctrl_any = 1'b0;
    tx_act = 2'b00;
    mstat_clear = 1'b0;
    v = 16'($urandom(32'h01df));
    do_reset(1'b1);
    rd(HWIRQ_ENABLE_OFS, HWIRQ_ENABLE_RST);
    rd(HWIRQ_OUT_EN_OFS, HWIRQ_OUT_EN_RST);
    rd(HWIRQ_PENDING_OFS, 16'h0000);
    rd(16'h0001, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      v = (i == 4) ? 16'hffff : 16'($urandom());
      wr(HWIRQ_ENABLE_OFS, v);
      rd(HWIRQ_ENABLE_OFS, v & HWIRQ_ENABLE_WMASK);
      wr(HWIRQ_OUT_EN_OFS, v);
      rd(HWIRQ_OUT_EN_OFS, v & HWIRQ_OUT_EN_WMASK);
    end
    // each event alone: host link, eeprom, ram init, ram parity
    for (int i = 0; i < 4; i++) begin
      v = (i < 2) ? (16'h8000 >> i) : 16'h2000;
      fire(4'b1000 >> i, v, 1'b1);
      rd(HWIRQ_PENDING_OFS, v);
      chk("mstat", {14'h0000, mst_ee, mst_ri}, {14'h0000, i >= 1, i == 2});
      clr_chk();
    end
    @(posedge mclk);
    mstat_clear <= 1'b1;
    @(posedge mclk);
    mstat_clear <= 1'b0;
    @(posedge mclk);
    chk("mstat_cl", {14'h0000, mst_ee, mst_ri}, 16'h0000);
    fire(4'b1100, 16'hc000, 1'b1);
    fire(4'b1100, 16'h0000, 1'b1);
    chk("mstat_clr", {14'h0000, mst_ee, mst_ri}, 16'h0002);
    clr_chk();
    wr(HWIRQ_ENABLE_OFS, 16'h0000);
    fire(4'b1111, 16'h0000, 1'b0);
    rd(HWIRQ_PENDING_OFS, 16'h0000);
    wr(HWIRQ_ENABLE_OFS, 16'hffff);
    wr(HWIRQ_OUT_EN_OFS, 16'h0000);
    fire(4'b1000, 16'h8000, 1'b0);
    clr_chk();
    wr(HWIRQ_OUT_EN_OFS, 16'hffff);
    term_any <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(HWIRQ_PENDING_OFS, 16'h0004);
    chk("irq_rt", {15'h0000, irq}, 16'h0000);
    term_any <= 1'b0;
    ctrl_any <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(HWIRQ_PENDING_OFS, 16'h0001);
    chk("irq_sum", {15'h0000, irq}, 16'h0000);
    ctrl_any <= 1'b0;
    for (int t = 0; t < 2; t++) begin
      tx_act <= 2'(1 << t);
      log_exp.push_back(16'h2000);
      repeat (WD) @(posedge mclk);
      chk("tx_early", {14'h0000, tx_inh}, 16'h0000);
      repeat (4) @(posedge mclk);
      chk("tx_inh", {14'h0000, tx_inh}, 16'(1 << t));
      chk("irq_wd", {15'h0000, irq}, 16'h0001);
      tx_act <= 2'b00;
      clr_chk();
    end
    do_reset(1'b0);
    @(posedge mclk);
    fire(4'b0110, 16'h0000, 1'b0);
    rd(HWIRQ_PENDING_OFS, 16'h0000);
    chk("mstat_strap", {14'h0000, mst_ee, mst_ri}, 16'h0000);
    repeat (4) @(posedge mclk);
    chk("log_left", 16'(log_exp.size()), 16'h0000);
    complete_run();
  end
endmodule
